// *** shared/lcs_pkg.sv ***
// package for the li-ion charger sequencer: register map, fields, timing
package lcs_pkg;
    // ****************************************************************
    // register map (byte addresses, one word each)
    // ****************************************************************
    localparam logic [3:0] ADDR_CONFIG = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h4;
    localparam logic [3:0] ADDR_IND_ON = 4'h8;
    localparam logic [3:0] ADDR_IND_PER = 4'hc;
    localparam int ADDR_W = 4;
    // ****************************************************************
    // charge_config_register fields
    // ****************************************************************
    localparam int CFG_CHG_DIS = 0;
    localparam int CFG_USB_DIS = 1;
    localparam int CFG_USB_HI = 2;
    localparam int CFG_RED_LO = 3;
    localparam int CFG_TMR_EN = 5;
    localparam int CFG_RESET = 6;
    localparam logic [7:0] CFG_RESET_VAL = 8'h00;
    // ****************************************************************
    // charge_status_register fields (write one to clear 0..3)
    // ****************************************************************
    localparam int ST_PRE_FAULT = 0;
    localparam int ST_FAST_FAULT = 1;
    localparam int ST_TAPER = 2;
    localparam int ST_TERM = 3;
    localparam int ST_AC_SEL = 4;
    localparam int ST_USB_SEL = 5;
    localparam int ST_PHASE_LO = 8;
    localparam int ST_ILIM_LO = 12;
    // ****************************************************************
    // current codes driven to the analog regulator
    // ****************************************************************
    localparam logic [3:0] I_OFF = 4'h0;
    localparam logic [3:0] I_DETECT = 4'h1;
    localparam logic [3:0] I_PRE = 4'h2; // one tenth of fast current
    localparam logic [3:0] I_USB100 = 4'h3;
    localparam logic [3:0] I_USB500 = 4'h4;
    localparam logic [3:0] I_AC100 = 4'h8; // ac 100,75,50,25 percent: 8..b
    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int CLK_HZ = 20000000;
    localparam int USB_DLY_MS = 10;
    localparam int USB_DLY_CYC = USB_DLY_MS * (CLK_HZ / 1000);
    localparam int PRE_TMO_S = 1800;
    localparam int FAST_TMO_S = 18000;
    localparam int TAPER_TMO_S = 1800;
    localparam int TICK_CYC = CLK_HZ; // one second tick
    typedef enum logic [2:0] {SLEEP, USBWAIT, PRECHG, FASTCHG, VREG, DONE, FAULT}
        lcs_phase_t;
    // comparator inputs from the analog front end
    typedef struct packed {
        logic acValid;     // ac above battery + 100 mV
        logic acOver;      // ac above overvoltage limit
        logic usbValid;    // usb above battery + 100 mV
        logic battLow;     // below precharge_exit_threshold
        logic battRecharge; // below recharge_threshold
        logic inVreg;      // voltage regulation loop in control
        logic taperSeen;   // current below taper level
        logic termSeen;    // current below termination level
        logic tempOk;      // thermistor_sense inside window
        logic junctionHot; // junction above 145 C
        logic battReplaced; // replacement seen at detect current
    } lcs_sense_t;
endpackage

// *** verilog/lcs_sequencer.sv ***
// charger sequencer: source select, charge phases, timers, indicator, avalon slave
`timescale 1ns/10ps
module lcs_sequencer #(
    parameter int USB_DLY = lcs_pkg::USB_DLY_CYC,
    parameter int TICK = lcs_pkg::TICK_CYC,
    parameter int PRE_TMO = lcs_pkg::PRE_TMO_S,
    parameter int FAST_TMO = lcs_pkg::FAST_TMO_S,
    parameter int TAPER_TMO = lcs_pkg::TAPER_TMO_S
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic [lcs_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire lcs_pkg::lcs_sense_t sense,
    output logic chargeOn,
    output logic [3:0] chargeCurrent,
    output logic useAc,
    output logic useUsb,
    output logic chargeIrq,
    output logic supplyGoodOut,
    output logic supplyGoodOe
);
    // ****************************************************************
    // register bus: one wait state, answer on second cycle
    // ****************************************************************
    logic ack_q;
    logic [7:0] cfg_q;
    logic [3:0] stFlags_q;
    logic [7:0] indOn_q;
    logic [7:0] indPer_q;
    logic [31:0] rdMux;
    wire busReq = (avs_read | avs_write) & ~ack_q;
    wire wrAck = avs_write & ack_q;
    wire wrCfg = wrAck & (avs_address == lcs_pkg::ADDR_CONFIG);
    wire wrSt = wrAck & (avs_address == lcs_pkg::ADDR_STATUS);
    wire wrOn = wrAck & (avs_address == lcs_pkg::ADDR_IND_ON);
    wire wrPer = wrAck & (avs_address == lcs_pkg::ADDR_IND_PER);
    lcs_pkg::lcs_phase_t phase_q;
    logic [3:0] iNext;
    always_comb
    begin
        case (avs_address)
            lcs_pkg::ADDR_CONFIG: rdMux = {24'h000000, cfg_q};
            lcs_pkg::ADDR_STATUS: rdMux = {16'h0000, iNext, 1'b0, phase_q,
                2'h0, useUsb, useAc, stFlags_q};
            lcs_pkg::ADDR_IND_ON: rdMux = {24'h000000, indOn_q};
            lcs_pkg::ADDR_IND_PER: rdMux = {24'h000000, indPer_q};
            default: rdMux = 32'h00000000; // unmapped reads zero, writes dropped
        endcase
    end
    // ack toggles so that each request gets exactly one low waitrequest
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ack_q <= 1'b0;
            avs_readdata <= 32'h00000000;
        end
        else
        begin
            ack_q <= busReq;
            if (busReq)
                avs_readdata <= rdMux;
        end
    end
    assign avs_waitrequest = ~ack_q;
    // config and indicator registers; reset leaves fast and taper timers disabled
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cfg_q <= lcs_pkg::CFG_RESET_VAL;
            indOn_q <= 8'h00;
            indPer_q <= 8'h00;
        end
        else
        begin
            if (wrCfg)
                cfg_q <= avs_writedata[7:0];
            if (wrOn)
                indOn_q <= avs_writedata[7:0];
            if (wrPer)
                indPer_q <= avs_writedata[7:0];
        end
    end
    // ****************************************************************
    // source selection and gating
    // ****************************************************************
    wire hostRst = cfg_q[lcs_pkg::CFG_RESET];
    wire acOk = sense.acValid & ~sense.acOver;
    wire selAc = acOk;
    wire selUsb = ~sense.acValid & sense.usbValid;
    wire noSupply = ~sense.acValid & ~sense.usbValid;
    wire usbOff = selUsb & cfg_q[lcs_pkg::CFG_USB_DIS];
    wire chgAllowed = ~cfg_q[lcs_pkg::CFG_CHG_DIS] & ~hostRst & ~usbOff
        & (selAc | selUsb);
    wire suspend = ~sense.tempOk | sense.junctionHot;
    wire tmrEn = cfg_q[lcs_pkg::CFG_TMR_EN];
    wire [1:0] acRed = cfg_q[lcs_pkg::CFG_RED_LO+1:lcs_pkg::CFG_RED_LO];
    wire [3:0] fastI = selAc ? (lcs_pkg::I_AC100 | {2'b00, acRed})
        : (cfg_q[lcs_pkg::CFG_USB_HI] ? lcs_pkg::I_USB500 : lcs_pkg::I_USB100);
    // ****************************************************************
    // timers: one-second tick, seconds counters
    // ****************************************************************
    logic [31:0] tick_q;
    logic [31:0] dly_q;
    logic [15:0] preT_q;
    logic [15:0] fastT_q;
    logic [15:0] taperT_q;
    wire tickEn = (tick_q == 32'(TICK - 1));
    wire preExp = (preT_q == 16'(PRE_TMO));
    wire fastExp = (fastT_q == 16'(FAST_TMO));
    wire taperExp = (taperT_q == 16'(TAPER_TMO));
    wire dlyDone = (dly_q == 32'(USB_DLY));
    wire taperHold = (phase_q == lcs_pkg::VREG) & sense.taperSeen;
    // ****************************************************************
    // phase machine
    // ****************************************************************
    lcs_pkg::lcs_phase_t phase_d;
    wire inCharge = (phase_q == lcs_pkg::PRECHG) | (phase_q == lcs_pkg::FASTCHG)
        | (phase_q == lcs_pkg::VREG);
    always_comb
    begin
        phase_d = phase_q;
        case (phase_q)
            lcs_pkg::SLEEP:
                if (!noSupply)
                    phase_d = selUsb ? lcs_pkg::USBWAIT : lcs_pkg::PRECHG;
            lcs_pkg::USBWAIT:
                if (selAc)
                    phase_d = lcs_pkg::PRECHG;
                else if (dlyDone)
                    phase_d = lcs_pkg::PRECHG;
            lcs_pkg::PRECHG:
                if (preExp)
                    phase_d = lcs_pkg::FAULT;
                else if (!sense.battLow)
                    phase_d = lcs_pkg::FASTCHG;
            lcs_pkg::FASTCHG:
                if (tmrEn && fastExp)
                    phase_d = lcs_pkg::FAULT;
                else if (sense.termSeen && !suspend)
                    phase_d = lcs_pkg::DONE;
                else if (sense.inVreg)
                    phase_d = lcs_pkg::VREG;
            lcs_pkg::VREG:
                if (tmrEn && fastExp)
                    phase_d = lcs_pkg::FAULT;
                else if ((tmrEn && taperExp) || (sense.termSeen && !suspend))
                    phase_d = lcs_pkg::DONE;
                else if (!sense.inVreg)
                    phase_d = lcs_pkg::FASTCHG;
            lcs_pkg::DONE:
                if (sense.battRecharge)
                    phase_d = lcs_pkg::PRECHG;
            lcs_pkg::FAULT:
                if (sense.battReplaced)
                    phase_d = lcs_pkg::PRECHG;
            default: phase_d = lcs_pkg::SLEEP;
        endcase
        if (noSupply)
            phase_d = lcs_pkg::SLEEP;
        else if (phase_q == lcs_pkg::SLEEP && phase_d == lcs_pkg::PRECHG && selUsb)
            phase_d = lcs_pkg::USBWAIT;
    end
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            phase_q <= lcs_pkg::SLEEP;
        else
            phase_q <= phase_d;
    end
    // timer counters; suspend holds the seconds counters rather than clearing them, the usb delay keeps counting
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            tick_q <= 32'h00000000;
            dly_q <= 32'h00000000;
            preT_q <= 16'h0000;
            fastT_q <= 16'h0000;
            taperT_q <= 16'h0000;
        end
        else
        begin
            tick_q <= tickEn ? 32'h00000000 : tick_q + 32'h00000001;
            if (phase_q != lcs_pkg::USBWAIT)
                dly_q <= 32'h00000000;
            else if (!dlyDone && !usbOff)
                dly_q <= dly_q + 32'h00000001; // host may hold it off
            if (phase_q != lcs_pkg::PRECHG)
                preT_q <= 16'h0000;
            else if (tickEn && !suspend && !preExp)
                preT_q <= preT_q + 16'h0001;
            if (!tmrEn || (phase_q != lcs_pkg::VREG && phase_q != lcs_pkg::FASTCHG)
                || (phase_q == lcs_pkg::VREG && !sense.inVreg))
                fastT_q <= 16'h0000;
            else if (tickEn && !suspend && !fastExp && !taperHold)
                fastT_q <= fastT_q + 16'h0001;
            if (!tmrEn || phase_q != lcs_pkg::VREG || !sense.taperSeen)
                taperT_q <= 16'h0000;
            else if (tickEn && !suspend && !taperExp)
                taperT_q <= taperT_q + 16'h0001;
        end
    end
    // ****************************************************************
    // status flags: set wins over host clear
    // ****************************************************************
    wire newBatt = (phase_q == lcs_pkg::DONE && sense.battRecharge)
        || (phase_q == lcs_pkg::FAULT && sense.battReplaced);
    wire setPre = (phase_q == lcs_pkg::PRECHG) && (phase_d == lcs_pkg::FAULT);
    wire setFast = (phase_q != lcs_pkg::PRECHG) && (phase_q != lcs_pkg::FAULT)
        && (phase_d == lcs_pkg::FAULT);
    wire setTaper = (phase_q == lcs_pkg::VREG) && (phase_d == lcs_pkg::DONE) && tmrEn && taperExp;
    wire setTerm = (phase_q != lcs_pkg::DONE) && (phase_d == lcs_pkg::DONE) && !setTaper;
    wire [3:0] setVec = {setTerm, setTaper, setFast, setPre};
    wire [3:0] clrVec = (wrSt ? avs_writedata[3:0] : 4'h0)
        | (newBatt ? 4'hf : 4'h0);
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            stFlags_q <= 4'h0;
        else
            stFlags_q <= (stFlags_q & ~clrVec) | setVec;
    end
    // ****************************************************************
    // outputs to the power stage
    // ****************************************************************
    always_comb
    begin
        iNext = lcs_pkg::I_OFF;
        if (phase_q == lcs_pkg::FAULT)
            iNext = lcs_pkg::I_DETECT;
        else if (inCharge && chgAllowed && !suspend)
            iNext = (phase_q == lcs_pkg::PRECHG) ? lcs_pkg::I_PRE : fastI;
    end
    // ****************************************************************
    // supply good indicator: charger driven or blink by registers
    // ****************************************************************
    logic [7:0] blink_q;
    wire blinkOn = (indPer_q != 8'h00) && (blink_q < indOn_q);
    wire pgChg = (acOk | sense.usbValid) && (phase_q != lcs_pkg::SLEEP);
    wire pgUser = (indOn_q != 8'h00) || (indPer_q != 8'h00);
    wire pgOn = pgUser ? ((indPer_q == 8'h00) ? 1'b1 : blinkOn) : pgChg;
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            blink_q <= 8'h00;
            chargeOn <= 1'b0;
            chargeCurrent <= lcs_pkg::I_OFF;
            useAc <= 1'b0;
            useUsb <= 1'b0;
            chargeIrq <= 1'b0;
            supplyGoodOut <= 1'b0;
            supplyGoodOe <= 1'b0;
        end
        else
        begin
            if (tickEn)
                blink_q <= (blink_q + 8'h01 >= indPer_q) ? 8'h00 : blink_q + 8'h01;
            chargeOn <= (iNext != lcs_pkg::I_OFF);
            chargeCurrent <= iNext;
            useAc <= selAc;
            useUsb <= selUsb;
            chargeIrq <= |stFlags_q;
            supplyGoodOut <= 1'b0; // open drain, low means on
            supplyGoodOe <= pgOn && !hostRst;
        end
    end
    // ****************************************************************
    // checks
    // ****************************************************************
    AST_AC_PRIO: assert property (@(posedge core_clk) disable iff (!rst_b)
        (sense.acValid && !sense.acOver) |=> useAc && !useUsb) else $error("ac not chosen");
    AST_OVP: assert property (@(posedge core_clk) disable iff (!rst_b)
        (sense.acOver && !sense.usbValid && phase_q != lcs_pkg::FAULT) |=>
        chargeCurrent == lcs_pkg::I_OFF) else $error("charging from overvoltage ac");
    AST_TEMP: assert property (@(posedge core_clk) disable iff (!rst_b)
        !sense.tempOk && phase_q != lcs_pkg::FAULT |=> !chargeOn) else $error("hot");
    AST_HOT: assert property (@(posedge core_clk) disable iff (!rst_b)
        sense.junctionHot && phase_q != lcs_pkg::FAULT |=> chargeCurrent == lcs_pkg::I_OFF)
        else $error("junction hot charge");
    AST_DIS: assert property (@(posedge core_clk) disable iff (!rst_b)
        cfg_q[lcs_pkg::CFG_CHG_DIS] && phase_q != lcs_pkg::FAULT |=> !chargeOn)
        else $error("charge while disabled");
    AST_FREEZE: assert property (@(posedge core_clk) disable iff (!rst_b)
        suspend && phase_q == phase_d |=> $stable(fastT_q) && $stable(taperT_q))
        else $error("timer moved in suspend");
    AST_NOTMR: assert property (@(posedge core_clk) disable iff (!rst_b)
        !tmrEn |=> fastT_q == 16'h0000) else $error("timer without enable");
    AST_PGZ: assert property (@(posedge core_clk) disable iff (!rst_b)
        hostRst |=> !supplyGoodOe) else $error("indicator driven in reset");
    AST_SLEEP: assert property (@(posedge core_clk) disable iff (!rst_b)
        noSupply |=> phase_q == lcs_pkg::SLEEP ##1 !supplyGoodOe || pgUser)
        else $error("no sleep");
    AST_PREI: assert property (@(posedge core_clk) disable iff (!rst_b)
        phase_q == lcs_pkg::PRECHG && chgAllowed && !suspend |=> chargeCurrent == lcs_pkg::I_PRE)
        else $error("wrong precharge current");
    COV_FULL: cover property (@(posedge core_clk) phase_q == lcs_pkg::VREG ##1
        phase_q == lcs_pkg::DONE);
    COV_FAULT: cover property (@(posedge core_clk) phase_q == lcs_pkg::PRECHG ##1
        phase_q == lcs_pkg::FAULT);
    COV_USB: cover property (@(posedge core_clk) phase_q == lcs_pkg::USBWAIT ##1
        phase_q == lcs_pkg::PRECHG);
endmodule

// *** verification/lcs_supply_model.sv ***
// far-side model: ac adapter, usb supply, battery cell and thermistor comparators
`timescale 1ns/10ps
module lcs_supply_model #(
    parameter int LOWV_MV = 3000,
    parameter int RCH_MV = 4100,
    parameter int VREG_MV = 4200,
    parameter int TAPER_MA = 100,
    parameter int TERM_MA = 20
) (
    input wire logic core_clk,
    output lcs_pkg::lcs_sense_t sense
);
    // analog levels, changed by the bench just after a clock edge
    int acMv = 0;
    int usbMv = 0;
    int battMv = 2800;
    int chgMa = 500;
    int tempC = 25;
    int junctionC = 60;
    logic swapped = 1'b0;
    // comparators are sampled once a cycle, so a level change shows one edge late
    always_ff @(posedge core_clk)
    begin
        sense.acValid <= acMv > battMv + 100;
        sense.acOver <= acMv > 6600;
        sense.usbValid <= usbMv > battMv + 100;
        sense.battLow <= battMv < LOWV_MV;
        sense.battRecharge <= battMv < RCH_MV;
        sense.inVreg <= battMv >= VREG_MV;
        sense.taperSeen <= chgMa < TAPER_MA;
        sense.termSeen <= chgMa < TERM_MA;
        sense.tempOk <= tempC >= 0 && tempC <= 45;
        sense.junctionHot <= junctionC > 145;
        sense.battReplaced <= swapped;
    end
endmodule

// *** verification/testbench.sv ***
// self-checking bench: avalon register tasks and charge sequences
`timescale 1ns/10ps
module testbench;
    logic coreClk;
    logic rstB;
    logic [3:0] avsAddress;
    logic avsRead;
    logic avsWrite;
    logic [31:0] avsWritedata;
    logic [31:0] avsReaddata;
    logic avsWaitrequest;
    lcs_pkg::lcs_sense_t sense;
    logic chargeOn;
    logic [3:0] chargeCurrent;
    logic useAc;
    logic useUsb;
    logic chargeIrq;
    logic supplyGoodOut;
    logic supplyGoodOe;
    logic [31:0] q;
    int badCount = 0;
    int cmpCount = 0;
    // short counts keep every timer inside a few dozen cycles
    lcs_sequencer #(.USB_DLY(8), .TICK(4), .PRE_TMO(3), .FAST_TMO(3), .TAPER_TMO(3)) i_dut (
        .core_clk(coreClk), .rst_b(rstB), .avs_address(avsAddress), .avs_read(avsRead),
        .avs_write(avsWrite), .avs_writedata(avsWritedata), .avs_readdata(avsReaddata),
        .avs_waitrequest(avsWaitrequest), .sense(sense), .chargeOn(chargeOn),
        .chargeCurrent(chargeCurrent), .useAc(useAc), .useUsb(useUsb), .chargeIrq(chargeIrq),
        .supplyGoodOut(supplyGoodOut), .supplyGoodOe(supplyGoodOe));
    lcs_supply_model i_model (.core_clk(coreClk), .sense(sense));
    // ****************************************************************
    // clock, tasks and watchdog
    // ****************************************************************
    initial
    begin
        coreClk = 1'b0;
        forever #25 coreClk = ~coreClk;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmpCount++;
        if (seen !== exp)
        begin
            badCount++;
            $display("CHECK FAILED at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one avalon transfer; the idle edge at the end keeps strobes from toggling twice
    task automatic busOp(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        avsAddress <= a;
        avsWritedata <= d;
        avsWrite <= wr;
        avsRead <= ~wr;
        @(posedge coreClk);
        while (avsWaitrequest !== 1'b0 && n < 40)
        begin
            @(posedge coreClk);
            n++;
        end
        chk(32'(n < 40), 32'h1);
        q = avsReaddata;
        avsWrite <= 1'b0;
        avsRead <= 1'b0;
        @(posedge coreClk);
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge coreClk);
    endtask
    // poll the status word until one flag reaches the wanted level, bounded
    task automatic waitSt(input int idx, input logic v);
        int n;
        n = 0;
        busOp(1'b0, lcs_pkg::ADDR_STATUS, 32'h0);
        while (q[idx] !== v && n < 60)
        begin
            busOp(1'b0, lcs_pkg::ADDR_STATUS, 32'h0);
            n++;
        end
    endtask
    task automatic swap;
        i_model.swapped <= 1'b1;
        settle(3);
        i_model.swapped <= 1'b0;
        settle(2);
    endtask
    task automatic closeOut;
        $display("comparisons %0d, mismatches %0d", cmpCount, badCount);
        if (badCount == 0 && cmpCount > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (20000) @(posedge coreClk);
        badCount++;
        closeOut();
    end
    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial
    begin
        rstB = 1'b0;
        avsAddress = 4'h0;
        avsRead = 1'b0;
        avsWrite = 1'b0;
        avsWritedata = 32'h0;
        q = 32'h0;
        repeat (6) @(posedge coreClk);
        rstB <= 1'b1;
        @(posedge coreClk);
        busOp(1'b0, lcs_pkg::ADDR_CONFIG, 32'h0);
        chk(q[7:0], lcs_pkg::CFG_RESET_VAL);
        busOp(1'b0, 4'h2, 32'h0);
        chk(q, 32'h0);
        busOp(1'b0, lcs_pkg::ADDR_STATUS, 32'h0);
        chk(q[10:8], 3'h0);
        chk({useAc, useUsb, chargeOn, supplyGoodOe}, 4'h0);
        // both supplies up on a deeply discharged cell
        i_model.acMv <= 5000;
        i_model.usbMv <= 5000;
        settle(5);
        chk({useAc, useUsb, supplyGoodOe}, 3'h5);
        chk(chargeCurrent, lcs_pkg::I_PRE);
        waitSt(lcs_pkg::ST_PRE_FAULT, 1'b1);
        chk(q[lcs_pkg::ST_PRE_FAULT], 1'b1);
        chk({chargeOn, chargeIrq, chargeCurrent}, {2'b11, lcs_pkg::I_DETECT});
        busOp(1'b1, lcs_pkg::ADDR_STATUS, 32'h1);
        busOp(1'b0, lcs_pkg::ADDR_STATUS, 32'h0);
        chk(q[lcs_pkg::ST_PRE_FAULT], 1'b0);
        i_model.battMv <= 3800;
        swap();
        settle(5);
        for (int r = 0; r < 4; r++)
        begin
            busOp(1'b1, lcs_pkg::ADDR_CONFIG, 32'(r << lcs_pkg::CFG_RED_LO));
            settle(3);
            chk(chargeCurrent, lcs_pkg::I_AC100 + 4'(r));
        end
        busOp(1'b1, lcs_pkg::ADDR_CONFIG, 32'h1 << lcs_pkg::CFG_CHG_DIS);
        settle(3);
        chk(chargeOn, 1'b0);
        busOp(1'b1, lcs_pkg::ADDR_CONFIG, 32'h0);
        // overvoltage on ac with usb gone, then cell and junction temperature
        i_model.usbMv <= 0;
        i_model.acMv <= 7000;
        settle(4);
        chk({chargeOn, supplyGoodOe}, 2'b00);
        i_model.acMv <= 5000;
        i_model.tempC <= 50;
        settle(5);
        chk(chargeOn, 1'b0);
        i_model.tempC <= 25;
        settle(5);
        chk(chargeOn, 1'b1);
        i_model.junctionC <= 150;
        settle(4);
        chk(chargeOn, 1'b0);
        i_model.junctionC <= 60;
        busOp(1'b1, lcs_pkg::ADDR_CONFIG, 32'h1 << lcs_pkg::CFG_RESET);
        settle(2);
        chk({supplyGoodOe, supplyGoodOut}, 2'b00);
        busOp(1'b1, lcs_pkg::ADDR_CONFIG, 32'h0);
        busOp(1'b1, lcs_pkg::ADDR_IND_PER, 32'h2);
        settle(12);
        chk(supplyGoodOe, 1'b0);
        busOp(1'b1, lcs_pkg::ADDR_IND_PER, 32'h0);
        busOp(1'b1, lcs_pkg::ADDR_IND_ON, 32'h2);
        settle(12);
        chk(supplyGoodOe, 1'b1);
        busOp(1'b1, lcs_pkg::ADDR_IND_ON, 32'h0);
        settle(40);
        busOp(1'b0, lcs_pkg::ADDR_STATUS, 32'h0);
        chk(q[lcs_pkg::ST_FAST_FAULT], 1'b0);
        // termination on low current, then recharge below the threshold
        i_model.battMv <= 4150;
        i_model.chgMa <= 10;
        waitSt(lcs_pkg::ST_TERM, 1'b1);
        chk({q[lcs_pkg::ST_TERM], chargeOn, chargeIrq}, 3'h5);
        i_model.chgMa <= 500;
        i_model.battMv <= 4000;
        settle(5);
        chk(chargeOn, 1'b1);
        busOp(1'b0, lcs_pkg::ADDR_STATUS, 32'h0);
        chk({q[lcs_pkg::ST_TERM], q[lcs_pkg::ST_TAPER], chargeIrq}, 3'h0);
        // safety timers switched on
        busOp(1'b1, lcs_pkg::ADDR_CONFIG, 32'h1 << lcs_pkg::CFG_TMR_EN);
        waitSt(lcs_pkg::ST_FAST_FAULT, 1'b1);
        chk({q[lcs_pkg::ST_FAST_FAULT], chargeCurrent}, {1'b1, lcs_pkg::I_DETECT});
        i_model.battMv <= 4200;
        i_model.chgMa <= 50;
        swap();
        busOp(1'b1, lcs_pkg::ADDR_STATUS, 32'hf);
        waitSt(lcs_pkg::ST_TAPER, 1'b1);
        chk({q[lcs_pkg::ST_TAPER], chargeOn}, 2'b10);
        // usb only from sleep: start delay, current steps, usb disable, then sleep
        busOp(1'b1, lcs_pkg::ADDR_CONFIG, 32'h0);
        i_model.acMv <= 0;
        i_model.battMv <= 3800;
        i_model.chgMa <= 500;
        settle(3);
        chk({useAc, chargeOn, supplyGoodOe}, 3'h0);
        i_model.usbMv <= 5000;
        settle(4);
        chk(chargeOn, 1'b0);
        settle(20);
        chk({useAc, useUsb, chargeOn, chargeCurrent}, {3'b011, lcs_pkg::I_USB100});
        busOp(1'b1, lcs_pkg::ADDR_CONFIG, (32'h1 << lcs_pkg::CFG_USB_HI) | 32'h18);
        settle(3);
        chk(chargeCurrent, lcs_pkg::I_USB500);
        busOp(1'b1, lcs_pkg::ADDR_CONFIG, 32'h1 << lcs_pkg::CFG_USB_DIS);
        settle(3);
        chk(chargeOn, 1'b0);
        i_model.usbMv <= 0;
        settle(5);
        busOp(1'b0, lcs_pkg::ADDR_STATUS, 32'h0);
        chk({q[10:8], supplyGoodOe}, 4'h0);
        closeOut();
    end
endmodule
